// ---- hw/ext_link.sv ----
// Extended command handler and record push engine
`timescale 1ns/1ns
`default_nettype none
`include "ext_link_regs.svh"
module ext_link
   import ext_link_pkg::*;
#(
   parameter int unsigned SEC_CYC = `SEC_CYCLES
) (
   input wire logic sys_clk, // Clock
   input wire logic rst_b, // Async reset
   input wire logic clk_en, // Freezes state when low
   input wire logic cmd_valid, // Decoded command strobe
   input wire cmd_t cmd, // Decoded command
   input wire logic realtime_en, // Real-time transmission on
   input wire logic relay_is_bell, // Relay drives bell
   input wire logic test_armed, // Test mode armed (nonvolatile)
   input wire logic card_valid, // New captured record
   input wire rec_t card_rec, // Captured record fields
   input wire logic date_ok, // Date field valid
   input wire logic time_ok, // Time field valid
   input wire card_fmt_t card_fmt, // Card encoding
   input wire logic [7:0] id_in, // ID byte to clean
   output logic card_ready, // Card reads accepted
   output logic store_req, // Store record pulse
   output logic reply_valid, // Reply strobe
   output reply_t reply, // Reply content
   output logic push_valid, // Push record strobe
   output rec_t push_rec, // Pushed record
   output logic id_zero, // Replace ID with ten zeros
   output logic [7:0] id_out, // Cleaned ID byte
   output logic arm_test, // Arm test mode pulse
   output logic init_busy, // Init shown on display
   output logic disp_valid, // Show message
   output logic [15:0] disp_digits, // Message digits
   output logic [7:0] relay_secs, // Relay activation seconds
   output logic [7:0] punch_count, // Stored punch count
   output logic ext_mode // Extended mode flag
);
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam logic [31:0] WAIT_CYC = 32'(`ACK_WAIT_S * SEC_CYC);
   localparam logic [31:0] GAP_CYC = 32'(`NEXT_GAP_S * SEC_CYC);
   localparam logic [31:0] INIT_CYC = 32'(`INIT_S * SEC_CYC);

   push_st_t state;
   logic [31:0] timer;
   logic [31:0] disp_timer;
   logic [7:0] punches;
   logic pend;
   logic fire;
   logic is_ack;
   logic push_mode;
   logic [6:0] len_max;
   logic boot; // First enabled edge after reset

   assign is_ack = cmd_valid && cmd.code == `CMD_ACK;
   assign push_mode = ext_mode || realtime_en;
   assign card_ready = state != ST_INIT && !(ext_mode && state == ST_WAIT);
   assign init_busy = state == ST_INIT;

   // Sanitise ID bytes and length
   always_comb begin
      unique case (card_fmt)
         FMT_TRK1: len_max = `LEN_MAX_TRK1;
         FMT_TRK2: len_max = `LEN_MAX_TRK2;
         default: len_max = `LEN_MAX_JIS;
      endcase
   end
   assign id_out = (id_in < 8'h20 || id_in > 8'h7F) ? 8'h5F : id_in;
   assign id_zero = push_rec.id_len == 7'h00 || push_rec.id_len > len_max;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_mode <= 1'b0;
         reply_valid <= 1'b0;
         reply <= '0;
         arm_test <= 1'b0;
         relay_secs <= 8'h00;
         punch_count <= 8'h00;
         disp_valid <= 1'b0;
         disp_digits <= 16'h0000;
         disp_timer <= 32'h0;
         punches <= 8'h00;
      end else if (clk_en) begin
         reply_valid <= 1'b0;
         arm_test <= 1'b0;
         reply <= '0;
         if (disp_timer != 32'h0) begin
            disp_timer <= disp_timer - 32'h1;
         end else begin
            disp_valid <= 1'b0;
         end
         if (card_valid && card_ready && ext_mode && punch_count != 8'h00) begin
            if (punches + 8'h01 >= punch_count) begin
               ext_mode <= 1'b0;
               punches <= 8'h00;
            end else begin
               punches <= punches + 8'h01;
            end
         end
         if (cmd_valid) begin
            unique case (cmd.code)
               `CMD_SELFTEST: begin
                  if (realtime_en && pend) begin
                     reply_valid <= 1'b1;
                     reply.err <= ERR_DENIED;
                  end else begin
                     arm_test <= 1'b1;
                  end
               end
               `CMD_LOGIN: begin
                  reply_valid <= 1'b1;
                  if (realtime_en) begin
                     reply.err <= ERR_DENIED;
                  end else begin
                     ext_mode <= 1'b1;
                     punches <= 8'h00;
                     reply.ack <= 1'b1;
                  end
               end
               `CMD_LOGOUT: begin
                  ext_mode <= 1'b0;
                  reply_valid <= 1'b1;
                  reply.ack <= 1'b1;
               end
               `CMD_STATUS: begin
                  reply_valid <= 1'b1;
                  reply.ack <= 1'b1;
                  reply.status_valid <= 1'b1;
                  reply.status_value <= {7'h00, ext_mode};
               end
               `CMD_PUNCH_GET: begin
                  reply_valid <= 1'b1;
                  if (!ext_mode) begin
                     reply.err <= ERR_DENIED;
                  end else begin
                     reply.ack <= 1'b1;
                     reply.status_valid <= 1'b1;
                     reply.status_value <= punch_count;
                  end
               end
               `CMD_ACK: begin
               end
               `CMD_RESEND: begin
                  if (!ext_mode) begin
                     reply_valid <= 1'b1;
                     reply.err <= ERR_DENIED;
                  end
               end
               default: begin
                  reply_valid <= 1'b1;
                  if (!ext_mode) begin
                     reply.err <= ERR_DENIED;
                  end else if (cmd.code == `CMD_DISPLAY) begin
                     if (cmd.secs == 8'h00 || cmd.secs > 8'h63) begin
                        reply.err <= ERR_PARAM;
                     end else begin
                        disp_valid <= 1'b1;
                        disp_digits <= cmd.digits;
                        disp_timer <= 32'(cmd.secs * SEC_CYC);
                        reply.ack <= 1'b1;
                     end
                  end else if (cmd.code == `CMD_RELAY) begin
                     if (relay_is_bell) begin
                        reply.err <= ERR_FAILED;
                     end else if (cmd.secs == 8'h00 || cmd.secs > 8'h63) begin
                        reply.err <= ERR_PARAM;
                     end else begin
                        relay_secs <= cmd.secs;
                        reply.ack <= 1'b1;
                     end
                  end else if (cmd.code == `CMD_PUNCH_SET) begin
                     if (cmd.value > `PUNCH_MAX) begin
                        reply.err <= ERR_PARAM;
                     end else begin
                        punch_count <= cmd.value;
                        punches <= 8'h00;
                        reply.ack <= 1'b1;
                     end
                  end else begin
                     reply.err <= ERR_FAILED;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Record push engine
   // ----------------------------------------
   assign fire = timer == 32'h0;

   // Push, ack wait, resend and pacing
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_INIT;
         timer <= 32'h1;
         pend <= 1'b0;
         push_valid <= 1'b0;
         push_rec <= '0;
         store_req <= 1'b0;
         boot <= 1'b1;
      end else if (clk_en) begin
         push_valid <= 1'b0;
         store_req <= 1'b0;
         if (!fire) begin
            timer <= timer - 32'h1;
         end
         if (card_valid && card_ready) begin
            store_req <= 1'b1;
            push_rec <= card_rec;
            if (!date_ok) begin
               push_rec.year <= `DEF_YEAR;
               push_rec.month <= `DEF_MONTH;
               push_rec.day <= `DEF_DAY;
            end
            if (!time_ok) begin
               push_rec.hour <= 8'h00;
               push_rec.minute <= 8'h00;
               push_rec.second <= 8'h00;
            end
            if (card_rec.event_code > 8'h01) begin
               push_rec.event_code <= 8'h00;
            end
            pend <= push_mode;
         end
         unique case (state)
            ST_INIT: begin
               // Only the first edge may start the restore, or it would reload forever
               boot <= 1'b0;
               if (boot && test_armed) begin
                  timer <= INIT_CYC;
               end else if (fire) begin
                  state <= ST_IDLE;
               end
            end
            ST_IDLE: begin
               if (pend) begin
                  push_valid <= 1'b1;
                  timer <= WAIT_CYC;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (is_ack) begin
                  pend <= card_valid && card_ready && push_mode;
                  timer <= GAP_CYC;
                  state <= ST_GAP;
               end else if ((cmd_valid && cmd.code == `CMD_RESEND && ext_mode) || fire) begin
                  push_valid <= 1'b1;
                  timer <= WAIT_CYC;
               end
            end
            ST_GAP: begin
               if (fire) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_login_ok;
      clk_en && cmd_valid && cmd.code == `CMD_LOGIN && !realtime_en;
   endsequence
   AST_LOGIN: assert property (@(posedge sys_clk) disable iff (!rst_b)
      s_login_ok |=> ext_mode && reply_valid && reply.ack)
      else $error("login did not enter extended mode");
   AST_LOGIN_RT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && cmd_valid && cmd.code == `CMD_LOGIN && realtime_en |=> reply.err == ERR_DENIED)
      else $error("login not refused in real time mode");
   AST_LOGOUT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && cmd_valid && cmd.code == `CMD_LOGOUT |=> !ext_mode)
      else $error("logout kept extended mode");
   AST_STATUS: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && cmd_valid && cmd.code == `CMD_STATUS |=> reply.status_value == {7'h00, $past(ext_mode)})
      else $error("status value wrong");
   AST_ACK_SILENT: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && is_ack |=> !reply_valid)
      else $error("ack answered");
   AST_SELFTEST: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && cmd_valid && cmd.code == `CMD_SELFTEST && !(realtime_en && pend) |=> arm_test && !reply_valid)
      else $error("self test not armed silently");
   AST_CARD_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ext_mode && state == ST_WAIT |-> !card_ready)
      else $error("card read accepted during ack wait");
   AST_RELAY_BELL: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && cmd_valid && cmd.code == `CMD_RELAY && ext_mode && relay_is_bell
      |=> reply.err == ERR_FAILED && $stable(relay_secs))
      else $error("relay duration accepted in bell mode");
   AST_PUNCH_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
      punch_count <= `PUNCH_MAX)
      else $error("punch count out of range");
   AST_ID_CLEAN: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (id_in < 8'h20) |-> id_out == 8'h5F)
      else $error("control byte not replaced");
endmodule : ext_link
`default_nettype wire

// ---- pkg/ext_link_pkg.sv ----
// Types for the extended-mode record link
package ext_link_pkg;
   typedef enum logic [1:0] {
      ERR_NONE = 2'h0,
      ERR_PARAM = 2'h1,
      ERR_FAILED = 2'h2,
      ERR_DENIED = 2'h3
   } err_t;
   typedef enum logic [1:0] {
      FMT_JIS = 2'h0,
      FMT_TRK1 = 2'h1,
      FMT_TRK2 = 2'h2
   } card_fmt_t;
   typedef struct packed {
      logic [7:0] code;
      logic [15:0] digits;
      logic [7:0] secs;
      logic [7:0] value;
   } cmd_t;
   typedef struct packed {
      logic [15:0] number;
      logic [6:0] id_len;
      logic [7:0] event_code;
      logic [15:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } rec_t;
   typedef struct packed {
      logic ack;
      err_t err;
      logic status_valid;
      logic [7:0] status_value;
   } reply_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_GAP = 2'b10,
      ST_INIT = 2'b11
   } push_st_t;
endpackage : ext_link_pkg

// ---- pkg/ext_link_regs.svh ----
// Constants for the extended-mode record link
`ifndef EXT_LINK_REGS_SVH
`define EXT_LINK_REGS_SVH
`define CMD_SELFTEST 8'h5A
`define CMD_LOGIN 8'h69
`define CMD_LOGOUT 8'h6F
`define CMD_STATUS 8'h73
`define CMD_RESEND 8'h72
`define CMD_ACK 8'h61
`define CMD_DISPLAY 8'h64
`define CMD_RELAY 8'h6C
`define CMD_PUNCH_SET 8'h70
`define CMD_PUNCH_GET 8'h75
`define PUNCH_MAX 8'h0A
`define LEN_MAX_JIS 7'h45
`define LEN_MAX_TRK1 7'h4C
`define LEN_MAX_TRK2 7'h25
`define DEF_YEAR 16'h1999
`define DEF_MONTH 8'h01
`define DEF_DAY 8'h01
`define CLK_HZ 25000000
`define ACK_WAIT_S 5
`define NEXT_GAP_S 1
`define INIT_S 25
`define SEC_CYCLES `CLK_HZ
`endif

// ---- test/ext_host_model.sv ----
// Host computer model: sends commands, answers pushed records
`timescale 1ns/1ns
`default_nettype none
`include "ext_link_regs.svh"
module ext_host_model
   import ext_link_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic push_valid, // Record pushed by device
   input wire logic auto_ack, // Answer pushes unprompted
   input wire logic [7:0] ack_delay, // Cycles before answering
   output var logic cmd_valid, // Command strobe
   output var cmd_t cmd // Command content
);
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // One command, held for one taking edge; released bus shows inverse
   task automatic send(input logic [7:0] code, input logic [15:0] d, input logic [7:0] s, input logic [7:0] v);
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b1;
      cmd = '{code, d, s, v};
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'b0;
      cmd = ~cmd;
   endtask : send
   // Acknowledge each pushed record after the set delay
   always @(posedge sys_clk) begin
      if (push_valid && auto_ack) begin
         repeat (ack_delay) @(posedge sys_clk);
         send(`CMD_ACK, 16'h0000, 8'h00, 8'h00);
      end
   end
endmodule : ext_host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the extended record link
`timescale 1ns/1ns
`default_nettype none
`include "ext_link_regs.svh"
module tb_top;
   import ext_link_pkg::*;
   localparam int S = 10;
   logic sys_clk, rst_b, cmd_valid, realtime_en, relay_is_bell, test_armed, card_valid, date_ok, time_ok;
   logic auto_ack, card_ready, store_req, reply_valid, push_valid, id_zero, arm_test, init_busy, disp_valid;
   logic ext_mode, clk_en;
   logic [7:0] id_in, id_out, relay_secs, punch_count;
   logic [15:0] disp_digits;
   cmd_t cmd;
   rec_t card_rec, push_rec;
   card_fmt_t card_fmt;
   reply_t reply, last_rep;
   int fails = 0, cmp_count = 0, rep_cnt = 0, push_cnt = 0, store_cnt = 0, arm_cnt = 0, cyc = 0, got;
   ext_link #(.SEC_CYC(S)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid),
      .cmd(cmd), .realtime_en(realtime_en), .relay_is_bell(relay_is_bell), .test_armed(test_armed),
      .card_valid(card_valid), .card_rec(card_rec), .date_ok(date_ok), .time_ok(time_ok), .card_fmt(card_fmt),
      .id_in(id_in), .card_ready(card_ready), .store_req(store_req), .reply_valid(reply_valid), .reply(reply),
      .push_valid(push_valid), .push_rec(push_rec), .id_zero(id_zero), .id_out(id_out), .arm_test(arm_test),
      .init_busy(init_busy), .disp_valid(disp_valid), .disp_digits(disp_digits), .relay_secs(relay_secs),
      .punch_count(punch_count), .ext_mode(ext_mode));
   ext_host_model u_host (.sys_clk(sys_clk), .push_valid(push_valid), .auto_ack(auto_ack),
      .ack_delay(8'h03), .cmd_valid(cmd_valid), .cmd(cmd));
   //---------------------------------------------------------------
   // Clock, event counters and hang guard
   //---------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (reply_valid) begin
         rep_cnt <= rep_cnt + 1;
         last_rep <= reply;
      end
      if (push_valid) push_cnt <= push_cnt + 1;
      if (store_req) store_cnt <= store_cnt + 1;
      if (arm_test) arm_cnt <= arm_cnt + 1;
      if (cyc == 8000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task automatic c(input logic [7:0] code, input logic [15:0] d = 0, input logic [7:0] s = 0, input logic [7:0] v = 0);
      int n0;
      n0 = rep_cnt;
      u_host.send(code, d, s, v);
      repeat (2) @(posedge sys_clk);
      #1;
      got = rep_cnt - n0;
   endtask : c
   task automatic r(input logic [7:0] code, input err_t e, input logic [15:0] d = 0, input logic [7:0] s = 0,
         input logic [7:0] v = 0);
      c(code, d, s, v);
      chk("reply count", got, 1);
      chk("reply err", last_rep.err, e);
   endtask : r
   task automatic card(input logic [6:0] len, input logic [7:0] ev, input logic ok);
      @(posedge sys_clk);
      #1;
      card_valid = 1'b1;
      card_rec = '{16'h0012, len, ev, 16'h2024, 8'h12, 8'h31, 8'h23, 8'h59, 8'h58};
      date_ok = ok;
      time_ok = ok;
      @(posedge sys_clk);
      #1;
      card_valid = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : card
   task automatic summarize();
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (10) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
   endtask : do_reset
   //---------------------------------------------------------------
   // Scenarios
   //---------------------------------------------------------------
   task automatic t_login();
      chk("ext after reset", ext_mode, 0);
      c(`CMD_STATUS);
      chk("status out", last_rep.status_value, 8'h00);
      r(`CMD_LOGIN, ERR_NONE);
      r(`CMD_LOGIN, ERR_NONE);
      c(`CMD_STATUS);
      chk("status in", last_rep.status_value, 8'h01);
      r(`CMD_LOGOUT, ERR_NONE);
      chk("ext out", ext_mode, 0);
      r(`CMD_DISPLAY, ERR_DENIED, 16'h1234, 8'h02);
      r(`CMD_RELAY, ERR_DENIED, 0, 8'h05);
      r(`CMD_RESEND, ERR_DENIED);
      r(`CMD_PUNCH_GET, ERR_DENIED);
      realtime_en = 1'b1;
      r(`CMD_LOGIN, ERR_DENIED);
      realtime_en = 1'b0;
      clk_en = 1'b0;
      c(`CMD_LOGIN);
      chk("frozen reply", got, 0);
      chk("frozen ext", ext_mode, 0);
      clk_en = 1'b1;
   endtask : t_login
   task automatic t_cmds();
      r(`CMD_LOGIN, ERR_NONE);
      r(`CMD_DISPLAY, ERR_NONE, 16'h1234, 8'h03);
      chk("disp on", disp_valid, 1);
      chk("disp digits", disp_digits, 16'h1234);
      repeat (3 * S - 4) @(posedge sys_clk);
      chk("disp held", disp_valid, 1);
      repeat (8) @(posedge sys_clk);
      chk("disp off", disp_valid, 0);
      r(`CMD_RELAY, ERR_NONE, 0, 8'h07);
      chk("relay secs", relay_secs, 8'h07);
      r(`CMD_RELAY, ERR_PARAM, 0, 8'h00);
      relay_is_bell = 1'b1;
      r(`CMD_RELAY, ERR_FAILED, 0, 8'h05);
      relay_is_bell = 1'b0;
      chk("relay kept", relay_secs, 8'h07);
      r(`CMD_PUNCH_SET, ERR_NONE, 0, 0, 8'h0A);
      r(`CMD_PUNCH_SET, ERR_PARAM, 0, 0, 8'h0B);
      c(`CMD_PUNCH_GET);
      chk("punch get", last_rep.status_value, 8'h0A);
      chk("punch count", punch_count, 8'h0A);
   endtask : t_cmds
   task automatic t_push();
      card(7'd0, 8'h03, 1'b0);
      chk("stored", store_cnt, 1);
      chk("pushed", push_cnt, 1);
      chk("event", push_rec.event_code, 8'h00);
      chk("date", {push_rec.year, push_rec.month, push_rec.day}, 32'h19990101);
      chk("time", {push_rec.hour, push_rec.minute, push_rec.second}, 24'h000000);
      chk("number", push_rec.number, 16'h0012);
      chk("id zero", id_zero, 1);
      chk("reads blocked", card_ready, 0);
      c(`CMD_RESEND);
      chk("resend", push_cnt, 2);
      repeat (5 * S + 2) @(posedge sys_clk);
      chk("timeout resend", push_cnt, 3);
      c(`CMD_ACK);
      chk("ack silent", got, 0);
      repeat (S + 3) @(posedge sys_clk);
      chk("reads back", card_ready, 1);
      #1;
      id_in = 8'h1F;
      #1 chk("id 1F", id_out, 8'h5F);
      id_in = 8'h7F;
      #1 chk("id 7F", id_out, 8'h7F);
      id_in = 8'h80;
      #1 chk("id 80", id_out, 8'h5F);
      card(7'd70, 8'h01, 1'b1);
      chk("event kept", push_rec.event_code, 8'h01);
      card_fmt = FMT_TRK1;
      #1 chk("len trk1", id_zero, 0);
      card_fmt = FMT_TRK2;
      #1 chk("len trk2", id_zero, 1);
      card_fmt = FMT_JIS;
      #1 chk("len jis", id_zero, 1);
      c(`CMD_ACK);
      repeat (S + 3) @(posedge sys_clk);
      #1;
   endtask : t_push
   task automatic t_punch();
      auto_ack = 1'b1;
      r(`CMD_LOGIN, ERR_NONE);
      r(`CMD_PUNCH_SET, ERR_NONE, 0, 0, 8'h02);
      card(7'd5, 8'h00, 1'b1);
      repeat (2 * S) @(posedge sys_clk);
      chk("still ext", ext_mode, 1);
      card(7'd5, 8'h00, 1'b1);
      repeat (2 * S) @(posedge sys_clk);
      #1 chk("auto logout", ext_mode, 0);
      auto_ack = 1'b0;
   endtask : t_punch
   task automatic t_self();
      realtime_en = 1'b1;
      card(7'd5, 8'h00, 1'b1);
      r(`CMD_SELFTEST, ERR_DENIED);
      chk("not armed", arm_cnt, 0);
      c(`CMD_ACK);
      repeat (S + 5) @(posedge sys_clk);
      c(`CMD_SELFTEST);
      chk("self silent", got, 0);
      chk("armed", arm_cnt, 1);
      realtime_en = 1'b0;
      test_armed = 1'b1;
      do_reset();
      repeat (25 * S - 10) @(posedge sys_clk);
      chk("init on", init_busy, 1);
      repeat (15) @(posedge sys_clk);
      chk("init off", init_busy, 0);
   endtask : t_self
   //---------------------------------------------------------------
   // Main sequence
   //---------------------------------------------------------------
   initial begin
      {realtime_en, relay_is_bell, test_armed, card_valid, date_ok, time_ok, auto_ack} = '0;
      clk_en = 1'b1;
      card_rec = '0;
      card_fmt = FMT_JIS;
      id_in = 8'h41;
      do_reset();
      repeat (3) @(posedge sys_clk);
      #1 chk("id 41", id_out, 8'h41);
      chk("no init", init_busy, 0);
      t_login();
      t_cmds();
      t_push();
      t_punch();
      t_self();
      summarize();
   end
endmodule : tb_top
`default_nettype wire
